// ===== rtl/sdram_params.svh
`ifndef SDRAM_PARAMS_SVH
`define SDRAM_PARAMS_SVH

// ****************************************
// geometry
// ****************************************
`define BANK_COUNT 4
`define BANK_W 2
`define COL_W 3
`define COL_COUNT 8
`define DATA_W 32
`define MASK_W 4
`define BURST_LEN 4
`define BURST_W 2
`define CAS_LATENCY 2

// ****************************************
// timing
// ****************************************
`define CLOCK_NS 50
`define TWR_NS 57
`define TWR_CYC (((`TWR_NS + `CLOCK_NS - 1) / `CLOCK_NS) < 1 ? 1 : ((`TWR_NS + `CLOCK_NS - 1) / `CLOCK_NS))
`define TRP_NS 20
`define TRP_CYC (((`TRP_NS + `CLOCK_NS - 1) / `CLOCK_NS) < 1 ? 1 : ((`TRP_NS + `CLOCK_NS - 1) / `CLOCK_NS))
`define TRC_NS 70
`define TRC_CYC (((`TRC_NS + `CLOCK_NS - 1) / `CLOCK_NS) < 1 ? 1 : ((`TRC_NS + `CLOCK_NS - 1) / `CLOCK_NS))
`define POWERUP_US 100
`define POWERUP_CYC ((`POWERUP_US * 1000 + `CLOCK_NS - 1) / `CLOCK_NS)
`define REFRESH_PERIOD_MS 64
`define REFRESH_ROWS 4096
`define REFRESH_INTERVAL_CYC ((`REFRESH_PERIOD_MS * 1000000) / `CLOCK_NS / `REFRESH_ROWS)
`define TIMER_W 4
`define WAIT_W 12
`define WAKE_REFRESHES 2

`endif

// ===== rtl/sdram_pkg.sv
`include "sdram_params.svh"

package sdram_pkg;

	// ****************************************
	// link commands, bank states and controller phases
	// ****************************************
	typedef enum logic [2:0] {
		cmd_nop,
		cmd_activate,
		cmd_read,
		cmd_write,
		cmd_precharge,
		cmd_refresh
	} cmd_t;

	typedef enum logic [1:0] {
		bank_idle,
		bank_active,
		bank_recover,
		bank_precharge
	} bank_state_t;

	typedef enum logic [1:0] {
		phase_wait,
		phase_refresh,
		phase_run
	} phase_t;

	// ****************************************
	// device state
	// ****************************************
	typedef struct packed {
		bank_state_t [`BANK_COUNT-1:0] bank_state;
		logic [`BANK_COUNT-1:0][`TIMER_W-1:0] bank_count;
		logic wr_on;
		logic [`BANK_W-1:0] wr_bank;
		logic [`COL_W-1:0] wr_col;
		logic [`BURST_W-1:0] wr_left;
		logic wr_ap;
		logic rd_on;
		logic [`BANK_W-1:0] rd_bank;
		logic [`COL_W-1:0] rd_col;
		logic [`BURST_W-1:0] rd_left;
		logic rd_ap;
		logic [`CAS_LATENCY-1:0] pipe_valid;
		logic [`CAS_LATENCY-1:0][`DATA_W-1:0] pipe_data;
		logic [`BANK_COUNT-1:0][`COL_COUNT-1:0][`DATA_W-1:0] mem;
	} device_state_t;

	// ****************************************
	// controller state
	// ****************************************
	typedef struct packed {
		phase_t phase;
		logic [`WAIT_W-1:0] wait_count;
		logic [1:0] refresh_left;
		logic [`WAIT_W-1:0] since_refresh;
		logic [`BANK_COUNT-1:0] ap_open;
		logic [`BANK_COUNT-1:0][`BURST_W-1:0] ap_left;
		logic [`BANK_COUNT-1:0][`TIMER_W-1:0] recover;
		cmd_t cmd;
		logic [`BANK_W-1:0] bank;
		logic [`COL_W-1:0] col;
		logic auto_pre;
		logic [`DATA_W-1:0] wdata;
		logic [`MASK_W-1:0] wmask;
		logic [`DATA_W-1:0] rdata;
		logic rvalid;
	} ctrl_state_t;

endpackage

// ===== rtl/sdram_link_if.sv
`timescale 1ns/1ps
`include "sdram_params.svh"

interface sdram_link_if (
	input wire logic clock
);
	sdram_pkg::cmd_t cmd;
	logic [`BANK_W-1:0] bank;
	logic [`COL_W-1:0] col;
	logic auto_pre;
	logic [`DATA_W-1:0] wdata;
	logic [`MASK_W-1:0] wmask;
	logic [`DATA_W-1:0] rdata;
	logic rdata_oe;

	modport device (
		input clock,
		input cmd,
		input bank,
		input col,
		input auto_pre,
		input wdata,
		input wmask,
		output rdata,
		output rdata_oe
	);

	modport controller (
		input clock,
		output cmd,
		output bank,
		output col,
		output auto_pre,
		output wdata,
		output wmask,
		input rdata,
		input rdata_oe
	);
endinterface

// ===== rtl/sdram_device.sv
`timescale 1ns/1ps
`include "sdram_params.svh"

module sdram_device (
	// link
	sdram_link_if.device link,
	// reset
	input wire logic rst_b
);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [`DATA_W-1:0] merge(
		input logic [`DATA_W-1:0] old_word,
		input logic [`DATA_W-1:0] new_word,
		input logic [`MASK_W-1:0] mask
	);
		logic [`DATA_W-1:0] result;
		result = old_word;
		for (int i = 0; i < `MASK_W; i++) begin
			if (!mask[i]) begin
				result[i*8 +: 8] = new_word[i*8 +: 8];
			end
		end
		return result;
	endfunction

	function automatic logic [`TIMER_W-1:0] cycles(input int value);
		return value[`TIMER_W-1:0];
	endfunction

	// ****************************************
	// state
	// ****************************************
	sdram_pkg::device_state_t s;
	sdram_pkg::device_state_t next_s;
	logic column_cmd;
	logic is_read;
	logic is_write;

	assign is_read = link.cmd == sdram_pkg::cmd_read;
	assign is_write = link.cmd == sdram_pkg::cmd_write;
	assign column_cmd = is_read || is_write;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_s = s;
		next_s.pipe_valid = {s.pipe_valid[`CAS_LATENCY-2:0], 1'b0};
		next_s.pipe_data = {s.pipe_data[`CAS_LATENCY-2:0], {`DATA_W{1'b0}}};

		// bank timers: recovery then precharge then idle
		for (int b = 0; b < `BANK_COUNT; b++) begin
			unique case (s.bank_state[b])
				sdram_pkg::bank_recover: begin
					if (s.bank_count[b] <= cycles(1)) begin
						next_s.bank_state[b] = sdram_pkg::bank_precharge;
						next_s.bank_count[b] = cycles(`TRP_CYC);
					end else begin
						next_s.bank_count[b] = s.bank_count[b] - cycles(1);
					end
				end
				sdram_pkg::bank_precharge: begin
					if (s.bank_count[b] <= cycles(1)) begin
						next_s.bank_state[b] = sdram_pkg::bank_idle;
						next_s.bank_count[b] = '0;
					end else begin
						next_s.bank_count[b] = s.bank_count[b] - cycles(1);
					end
				end
				sdram_pkg::bank_idle, sdram_pkg::bank_active: begin
				end
			endcase
		end

		// running write burst
		if (s.wr_on) begin
			if (!column_cmd) begin
				next_s.mem[s.wr_bank][s.wr_col] = merge(s.mem[s.wr_bank][s.wr_col], link.wdata, link.wmask);
				next_s.wr_col = s.wr_col + 1'b1;
				next_s.wr_left = s.wr_left - 1'b1;
				if (s.wr_left == '0) begin
					next_s.wr_on = 1'b0;
					if (s.wr_ap) begin
						// recovery counts from the last data edge
						next_s.bank_state[s.wr_bank] = sdram_pkg::bank_recover;
						next_s.bank_count[s.wr_bank] = cycles(`TWR_CYC);
					end
				end
			end else begin
				// cut short; data on this edge is not the old burst's
				next_s.wr_on = 1'b0;
				if (s.wr_ap) begin
					// recovery counts from the interrupting edge
					next_s.bank_state[s.wr_bank] = sdram_pkg::bank_recover;
					next_s.bank_count[s.wr_bank] = cycles(`TWR_CYC);
				end
			end
		end

		// running read burst
		if (s.rd_on) begin
			if (!column_cmd) begin
				next_s.pipe_valid[0] = 1'b1;
				next_s.pipe_data[0] = s.mem[s.rd_bank][s.rd_col];
				next_s.rd_col = s.rd_col + 1'b1;
				next_s.rd_left = s.rd_left - 1'b1;
				if (s.rd_left == '0) begin
					next_s.rd_on = 1'b0;
					if (s.rd_ap) begin
						next_s.bank_state[s.rd_bank] = sdram_pkg::bank_precharge;
						next_s.bank_count[s.rd_bank] = cycles(`TRP_CYC);
					end
				end
			end else begin
				next_s.rd_on = 1'b0;
				if (s.rd_ap) begin
					next_s.bank_state[s.rd_bank] = sdram_pkg::bank_precharge;
					next_s.bank_count[s.rd_bank] = cycles(`TRP_CYC);
				end
			end
		end

		// new command
		unique case (link.cmd)
			sdram_pkg::cmd_activate: begin
				next_s.bank_state[link.bank] = sdram_pkg::bank_active;
				next_s.bank_count[link.bank] = '0;
			end
			sdram_pkg::cmd_precharge: begin
				next_s.bank_state[link.bank] = sdram_pkg::bank_precharge;
				next_s.bank_count[link.bank] = cycles(`TRP_CYC);
			end
			sdram_pkg::cmd_write: begin
				// accepted even while another bank auto-precharges
				next_s.mem[link.bank][link.col] = merge(s.mem[link.bank][link.col], link.wdata, link.wmask);
				next_s.wr_on = `BURST_LEN > 1;
				next_s.wr_bank = link.bank;
				next_s.wr_col = link.col + 1'b1;
				next_s.wr_left = `BURST_W'(`BURST_LEN - 2);
				next_s.wr_ap = link.auto_pre;
				if (`BURST_LEN == 1 && link.auto_pre) begin
					next_s.bank_state[link.bank] = sdram_pkg::bank_recover;
					next_s.bank_count[link.bank] = cycles(`TWR_CYC);
				end
			end
			sdram_pkg::cmd_read: begin
				next_s.pipe_valid[0] = 1'b1;
				next_s.pipe_data[0] = s.mem[link.bank][link.col];
				next_s.rd_on = `BURST_LEN > 1;
				next_s.rd_bank = link.bank;
				next_s.rd_col = link.col + 1'b1;
				next_s.rd_left = `BURST_W'(`BURST_LEN - 2);
				next_s.rd_ap = link.auto_pre;
				if (`BURST_LEN == 1 && link.auto_pre) begin
					next_s.bank_state[link.bank] = sdram_pkg::bank_precharge;
					next_s.bank_count[link.bank] = cycles(`TRP_CYC);
				end
			end
			sdram_pkg::cmd_nop, sdram_pkg::cmd_refresh: begin
			end
			default: begin
			end
		endcase
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge link.clock) begin
		if (!rst_b) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ****************************************
	// read data after the latency
	// ****************************************
	assign link.rdata = s.pipe_data[`CAS_LATENCY-1];
	assign link.rdata_oe = s.pipe_valid[`CAS_LATENCY-1];

endmodule

// ===== rtl/sdram_controller.sv
`timescale 1ns/1ps
`include "sdram_params.svh"

module sdram_controller (
	// link
	sdram_link_if.controller link,
	// reset
	input wire logic rst_b,
	// user command
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire sdram_pkg::cmd_t cmd_op,
	input wire logic [`BANK_W-1:0] cmd_bank,
	input wire logic [`COL_W-1:0] cmd_col,
	input wire logic cmd_auto_pre,
	// user write data
	input wire logic [`DATA_W-1:0] wdata,
	input wire logic [`MASK_W-1:0] wmask,
	// user read data and status
	output logic [`DATA_W-1:0] rdata,
	output logic rvalid,
	output logic init_done
);

	// ****************************************
	// state
	// ****************************************
	sdram_pkg::ctrl_state_t s;
	sdram_pkg::ctrl_state_t next_s;
	logic refresh_now;
	logic column_go;

	assign refresh_now = s.phase == sdram_pkg::phase_run && !cmd_valid
		&& s.since_refresh >= `WAIT_W'(`REFRESH_INTERVAL_CYC / 2);
	assign cmd_ready = s.phase == sdram_pkg::phase_run && !(cmd_op == sdram_pkg::cmd_activate
		&& (s.recover[cmd_bank] != '0 || s.ap_open[cmd_bank]));
	assign column_go = cmd_valid && cmd_ready
		&& (cmd_op == sdram_pkg::cmd_read || cmd_op == sdram_pkg::cmd_write);

	always_comb begin
		next_s = s;
		next_s.cmd = sdram_pkg::cmd_nop;
		next_s.wdata = wdata;
		next_s.wmask = wmask;
		next_s.rdata = link.rdata;
		next_s.rvalid = link.rdata_oe;
		if (s.since_refresh != '1) begin
			next_s.since_refresh = s.since_refresh + 1'b1;
		end

		// per-bank recovery and auto precharge tracking
		for (int b = 0; b < `BANK_COUNT; b++) begin
			if (s.recover[b] != '0) begin
				next_s.recover[b] = s.recover[b] - 1'b1;
			end
			if (s.ap_open[b]) begin
				next_s.ap_left[b] = s.ap_left[b] - 1'b1;
				if (s.ap_left[b] == '0) begin
					next_s.ap_open[b] = 1'b0;
					next_s.recover[b] = `TIMER_W'(`TWR_CYC + `TRP_CYC);
				end
				if (column_go && cmd_bank != `BANK_W'(b)) begin
					next_s.ap_open[b] = 1'b0;
					next_s.recover[b] = `TIMER_W'(`TWR_CYC + `TRP_CYC);
				end
			end
		end

		unique case (s.phase)
			sdram_pkg::phase_wait: begin
				next_s.wait_count = s.wait_count + 1'b1;
				if (s.wait_count >= `WAIT_W'(`POWERUP_CYC - 1)) begin
					next_s.phase = sdram_pkg::phase_refresh;
					next_s.refresh_left = 2'(`WAKE_REFRESHES);
					next_s.wait_count = '0;
				end
			end
			sdram_pkg::phase_refresh: begin
				if (s.wait_count != '0) begin
					next_s.wait_count = s.wait_count - 1'b1;
				end else if (s.refresh_left != '0) begin
					next_s.cmd = sdram_pkg::cmd_refresh;
					next_s.refresh_left = s.refresh_left - 1'b1;
					next_s.wait_count = `WAIT_W'(`TRC_CYC - 1);
					next_s.since_refresh = '0;
				end else begin
					next_s.phase = sdram_pkg::phase_run;
				end
			end
			sdram_pkg::phase_run: begin
				if (s.since_refresh >= `WAIT_W'(`REFRESH_INTERVAL_CYC)) begin
					next_s.phase = sdram_pkg::phase_refresh;
					next_s.refresh_left = 2'(`WAKE_REFRESHES);
					next_s.wait_count = '0;
				end else if (refresh_now) begin
					next_s.cmd = sdram_pkg::cmd_refresh;
					next_s.since_refresh = '0;
				end else if (cmd_valid && cmd_ready) begin
					next_s.cmd = cmd_op;
					next_s.bank = cmd_bank;
					next_s.col = cmd_col;
					next_s.auto_pre = cmd_auto_pre;
					if (cmd_op == sdram_pkg::cmd_precharge) begin
						next_s.recover[cmd_bank] = `TIMER_W'(`TRP_CYC);
					end
					if (column_go && cmd_auto_pre) begin
						next_s.ap_open[cmd_bank] = 1'b1;
						next_s.ap_left[cmd_bank] = `BURST_W'(`BURST_LEN - 1);
					end
				end
			end
			default: begin
				next_s.phase = sdram_pkg::phase_wait;
			end
		endcase
	end

	always_ff @(posedge link.clock) begin
		if (!rst_b) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign link.cmd = s.cmd;
	assign link.bank = s.bank;
	assign link.col = s.col;
	assign link.auto_pre = s.auto_pre;
	assign link.wdata = s.wdata;
	assign link.wmask = s.wmask;
	assign rdata = s.rdata;
	assign rvalid = s.rvalid;
	assign init_done = s.phase == sdram_pkg::phase_run;

endmodule

// ===== bench/sdram_link_monitor.sv
`timescale 1ns/1ps
`include "sdram_params.svh"

module sdram_link_monitor (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// link
	input wire sdram_pkg::cmd_t cmd,
	input wire logic [`BANK_W-1:0] bank,
	input wire logic auto_pre,
	input wire logic rdata_oe
);
	localparam int FORCE_GAP = 313;
	logic [11:0] since_reset;
	logic [9:0] gap;
	logic [1:0] refreshes;
	logic [`BANK_W-1:0] ap_bank;

	// ****************************************
	// helper counters
	// ****************************************
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			since_reset <= 12'h000;
			gap <= 10'h000;
			refreshes <= 2'h0;
			ap_bank <= '0;
		end else begin
			if (since_reset != 12'hfff)
				since_reset <= since_reset + 12'h001;
			if (cmd == sdram_pkg::cmd_refresh)
				gap <= 10'h000;
			else if (gap != 10'h3ff)
				gap <= gap + 10'h001;
			if (cmd == sdram_pkg::cmd_refresh && refreshes != 2'h3)
				refreshes <= refreshes + 2'h1;
			if (cmd == sdram_pkg::cmd_write && auto_pre)
				ap_bank <= bank;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	sequence read_burst;
		cmd == sdram_pkg::cmd_read ##1 (cmd != sdram_pkg::cmd_write && cmd != sdram_pkg::cmd_precharge) [*3];
	endsequence

	sequence wake_pair;
		cmd == sdram_pkg::cmd_refresh ##2 cmd == sdram_pkg::cmd_refresh;
	endsequence

	AST_READ_LATENCY: assert property (cmd == sdram_pkg::cmd_read |-> ##2 rdata_oe)
		else $error("read data not out after latency");
	AST_READ_BURST: assert property (read_burst |-> rdata_oe [*3])
		else $error("read burst cut short");
	AST_OE_CAUSE: assert property (rdata_oe |-> $past(cmd, 2) == sdram_pkg::cmd_read
		|| $past(cmd, 3) == sdram_pkg::cmd_read || $past(cmd, 4) == sdram_pkg::cmd_read
		|| $past(cmd, 5) == sdram_pkg::cmd_read)
		else $error("read data without read");
	AST_WAKE_QUIET: assert property (since_reset < 12'h7d0 |-> cmd == sdram_pkg::cmd_nop)
		else $error("command during power-up wait");
	AST_WAKE_REFRESH_FIRST: assert property ((cmd != sdram_pkg::cmd_nop && refreshes < 2'h2)
		|-> cmd == sdram_pkg::cmd_refresh)
		else $error("access before two refreshes");
	AST_WAKE_PAIR: assert property ((gap >= FORCE_GAP && cmd == sdram_pkg::cmd_refresh) |-> wake_pair)
		else $error("overdue refresh not paired");
	AST_REFRESH_GAP: assert property (refreshes >= 2'h2 |-> gap < 10'h14a)
		else $error("refresh interval overrun");
	AST_NO_EARLY_ACTIVATE: assert property ((cmd == sdram_pkg::cmd_write && auto_pre)
		|=> (cmd != sdram_pkg::cmd_activate || bank != ap_bank) [*5])
		else $error("activate during write recovery");

	cover property (cmd == sdram_pkg::cmd_write && auto_pre ##[1:3] cmd == sdram_pkg::cmd_read);
endmodule

// ===== bench/tb_sdram_write_autopre_interrupt.sv
`timescale 1ns/1ps
`include "sdram_params.svh"

module tb_sdram_write_autopre_interrupt;
	logic clock;
	logic rst_b;
	logic cmd_valid;
	logic cmd_ready;
	sdram_pkg::cmd_t cmd_op;
	logic [`BANK_W-1:0] cmd_bank;
	logic [`COL_W-1:0] cmd_col;
	logic cmd_auto_pre;
	logic [`DATA_W-1:0] wdata;
	logic [`MASK_W-1:0] wmask;
	logic [`DATA_W-1:0] rdata;
	logic rvalid;
	logic init_done;
	logic [`DATA_W-1:0] mem_exp [`BANK_COUNT][`COL_COUNT];
	int miscompares = 0;
	int check_count = 0;
	int cycles = 0;
	int last_wait;
	int total_wait;
	int n;

	// ****************************************
	// clock, ends and monitor
	// ****************************************
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	sdram_link_if link (.clock(clock));
	sdram_device u_sdram_device (.link(link), .rst_b(rst_b));
	sdram_controller u_sdram_controller (.link(link), .rst_b(rst_b), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_bank(cmd_bank), .cmd_col(cmd_col),
		.cmd_auto_pre(cmd_auto_pre), .wdata(wdata), .wmask(wmask), .rdata(rdata), .rvalid(rvalid),
		.init_done(init_done));
	sdram_link_monitor u_sdram_link_monitor (.clock(clock), .rst_b(rst_b), .cmd(link.cmd),
		.bank(link.bank), .auto_pre(link.auto_pre), .rdata_oe(link.rdata_oe));

	// ****************************************
	// tasks
	// ****************************************
	task check(input logic [`DATA_W-1:0] got, input logic [`DATA_W-1:0] want);
		check_count++;
		if (got !== want) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, want);
		end
	endtask

	task give_verdict;
		$display("comparisons %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task go(input sdram_pkg::cmd_t op, input logic [`BANK_W-1:0] b, input logic [`COL_W-1:0] c,
		input logic ap, input logic [`DATA_W-1:0] d);
		logic ok;
		@(negedge clock);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_bank = b;
		cmd_col = c;
		cmd_auto_pre = ap;
		wdata = d;
		last_wait = -1;
		do begin
			#20;
			ok = cmd_ready;
			last_wait++;
			@(posedge clock);
		end while (ok !== 1'b1 && last_wait < 400);
		check({31'h0, ok}, 32'h1);
	endtask

	task beat(input logic [`DATA_W-1:0] d);
		@(negedge clock);
		cmd_op = sdram_pkg::cmd_nop;
		wdata = d;
	endtask

	task rd(input logic [`BANK_W-1:0] b, input logic [`COL_W-1:0] c, input logic [`DATA_W-1:0] d);
		int k;
		int t;
		k = 0;
		go(sdram_pkg::cmd_read, b, c, 1'b0, d);
		for (t = 0; t < 12 && k < 4; t++) begin
			beat(32'h0);
			if (rvalid === 1'b1) begin
				check(rdata, mem_exp[b][c + k[2:0]]);
				k++;
			end
		end
		check(32'(k), 32'h4);
	endtask

	always @(posedge clock) begin
		cycles++;
		if (cycles == 8000) begin
			miscompares++;
			give_verdict();
		end
	end

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		rst_b = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = sdram_pkg::cmd_nop;
		cmd_bank = '0;
		cmd_col = '0;
		cmd_auto_pre = 1'b0;
		wdata = '0;
		wmask = '0;
		foreach (mem_exp[i, j])
			mem_exp[i][j] = '0;
		repeat (2) @(negedge clock);
		rst_b = 1'b1;
		check({31'h0, init_done}, 32'h0);
		n = 0;
		while (init_done !== 1'b1 && n < 3000) begin
			@(negedge clock);
			n++;
		end
		check(32'(n >= 2000), 32'h1);
		for (int i = 0; i < 4; i++)
			go(sdram_pkg::cmd_activate, i[1:0], 3'h0, 1'b0, 32'h0);
		// write cut by write, then early activate
		go(sdram_pkg::cmd_write, 2'h0, 3'h0, 1'b1, 32'h11);
		beat(32'h12);
		go(sdram_pkg::cmd_write, 2'h1, 3'h0, 1'b0, 32'h21);
		go(sdram_pkg::cmd_activate, 2'h0, 3'h0, 1'b0, 32'h22);
		check(32'(last_wait != 0), 32'h1);
		beat(32'h22);
		beat(32'h22);
		mem_exp[0][0] = 32'h11;
		mem_exp[0][1] = 32'h12;
		mem_exp[1][0] = 32'h21;
		for (int j = 1; j < 4; j++)
			mem_exp[1][j] = 32'h22;
		rd(2'h0, 3'h0, 32'h0);
		rd(2'h1, 3'h0, 32'h0);
		// write cut by read to another bank
		go(sdram_pkg::cmd_write, 2'h2, 3'h4, 1'b1, 32'h31);
		beat(32'h32);
		beat(32'h33);
		mem_exp[2][4] = 32'h31;
		mem_exp[2][5] = 32'h32;
		mem_exp[2][6] = 32'h33;
		rd(2'h1, 3'h0, 32'h34);
		check(32'(last_wait), 32'h0);
		go(sdram_pkg::cmd_activate, 2'h2, 3'h0, 1'b0, 32'h0);
		// same cut again, activate asked at once
		go(sdram_pkg::cmd_write, 2'h2, 3'h4, 1'b1, 32'h31);
		beat(32'h32);
		beat(32'h33);
		go(sdram_pkg::cmd_read, 2'h1, 3'h0, 1'b0, 32'h34);
		go(sdram_pkg::cmd_activate, 2'h2, 3'h0, 1'b0, 32'h0);
		check(32'(last_wait != 0), 32'h1);
		repeat (4) beat(32'h0);
		rd(2'h2, 3'h4, 32'h0);
		// whole auto precharge burst
		go(sdram_pkg::cmd_write, 2'h3, 3'h0, 1'b1, 32'h41);
		for (int j = 1; j < 4; j++) begin
			beat(32'h41 + j);
			mem_exp[3][j] = 32'h41 + j;
		end
		mem_exp[3][0] = 32'h41;
		go(sdram_pkg::cmd_activate, 2'h3, 3'h0, 1'b0, 32'h0);
		check(32'(last_wait != 0), 32'h1);
		rd(2'h3, 3'h0, 32'h0);
		// requests held so long that refresh falls overdue
		total_wait = 0;
		for (int i = 0; i < 400; i++) begin
			go(sdram_pkg::cmd_nop, 2'h0, 3'h0, 1'b0, 32'h0);
			total_wait += last_wait;
		end
		check(32'(total_wait != 0), 32'h1);
		check({31'h0, init_done}, 32'h1);
		@(negedge clock);
		cmd_valid = 1'b0;
		repeat (4) @(negedge clock);
		give_verdict();
	end
endmodule
